// [logic/llac_pkg.sv]
// Package for the line link activation control block.
// Assumes a single 10 MHz system clock; shared by the block and its bench.
package llac_pkg;

  // ----------------------------------------------------------------
  // Clock and timing constants
  // ----------------------------------------------------------------
  localparam int unsigned CLK_HZ = 10000000;
  localparam int unsigned MS_PER_S = 1000;
  localparam int unsigned TICK_CYCLES = CLK_HZ / MS_PER_S;
  localparam int unsigned COLD_START_LIMIT_MS = 10000;
  localparam int unsigned WARM_START_LIMIT_MS = 5000;
  localparam int unsigned WARM_RESUME_LIMIT_MS = 100;
  localparam int unsigned ERROR_RESUME_LIMIT_MS = 300;
  localparam int unsigned SYNC_RECOVERY_LIMIT_MS = 200;
  localparam int unsigned MS_CNT_W = 14;
  localparam int unsigned TICK_CNT_W = 16;

  // ----------------------------------------------------------------
  // Line and record layout
  // ----------------------------------------------------------------
  localparam int unsigned MAX_BITS_PER_TONE = 12;
  localparam int unsigned BITS_W = 4;
  localparam int unsigned PERF_BYTES = 16;
  localparam int unsigned RATE_BYTE_LO = 0;
  localparam int unsigned FEC_CORR_BYTE_LO = 4;
  localparam int unsigned FEC_UNCORR_BYTE_LO = 8;

  // ----------------------------------------------------------------
  // Remote data register numbers
  // ----------------------------------------------------------------
  localparam logic [3:0] RREG_SELF_TEST = 4'h3;
  localparam logic [3:0] RREG_PERF = 4'h4;
  localparam logic [3:0] RREG_ATTEN = 4'h6;
  localparam logic [3:0] RREG_MARGIN = 4'h7;

  // ----------------------------------------------------------------
  // APB register byte offsets
  // ----------------------------------------------------------------
  localparam logic [7:0] OFS_CTRL = 8'h00;
  localparam logic [7:0] OFS_STATUS = 8'h04;
  localparam logic [7:0] OFS_CAPS = 8'h08;
  localparam logic [7:0] OFS_ATTEN = 8'h0C;
  localparam logic [7:0] OFS_MARGIN = 8'h10;
  localparam logic [7:0] OFS_RATE = 8'h14;
  localparam logic [7:0] OFS_FEC = 8'h18;
  localparam logic [7:0] OFS_BITCAP = 8'h1C;
  localparam logic [5:0] CTRL_RESET = 6'h00;
  localparam logic [3:0] CAPS_RESET = 4'h0;

  // Link state machine, one-hot
  typedef enum logic [6:0] {
    ST_SILENT = 7'h01,
    ST_INIT_RESET = 7'h02,
    ST_HANDSHAKE = 7'h04,
    ST_QUIET = 7'h08,
    ST_ACTIVATE = 7'h10,
    ST_STEADY = 7'h20,
    ST_IDLE = 7'h40
  } llac_state_t;

  // Activation kind selects which limit governs ST_ACTIVATE
  typedef enum logic [1:0] {
    ACT_COLD = 2'h0,
    ACT_WARM = 2'h1,
    ACT_RESUME = 2'h2,
    ACT_ERROR = 2'h3
  } llac_act_t;

  // Capability bits for the capabilities-list message
  typedef struct packed {
    logic l1_mode;
    logic us_low_band;
    logic ds_low_band;
    logic eoc_clear;
    logic npar3_dft;
    logic npar3_ce;
  } llac_caps_t;

  // Remote data register write from the overhead channel
  typedef struct packed {
    logic valid;
    logic [3:0] num;
    logic [3:0] byte_idx;
    logic [7:0] data;
  } llac_rreg_t;

endpackage

// [logic/llac_top.sv]
// Link activation and handshake control for the central-office line end.
// Assumes inputs synchronous to clk_in; handshake engine and remote
// overhead parser sit outside and report via plain strobes.
//
// Function
// - Never more than 12 bits per tone
// - Nonzero remote self-test clears link-up flag
// - Performance record: rate, correctable, uncorrectable
// - Expose remote attenuation and margin registers
// - Timeout false on entry, true after interval
// - Cold start fails after 10000 ms
// - Warm start expires after 5000 ms
// - Warm resume expires after 100 ms
// - Error resume expires after 300 ms
// - Sync recovery expires after 200 ms
// - Idle set on idle, cleared on steady
// - Success only when state procedures errorless
// - Power-up, signal loss, init error outside steady: silent state
// - Network may order init reset, then handshake
// - Mode selected: quiet state after handshake
// - Handshake carries DFT size, CE, low-band flags
// - Advertise mode with level 1 bit set
// - Each set level 2 bit carries parameter field
// - Low-band flags only where band usable
// - Clear overhead flag only if frames supported
`timescale 1ns/1ps

module llac_top #(
  parameter int unsigned TICK_CYCLES = llac_pkg::TICK_CYCLES
) (
  input wire logic clk_in, // System clock, 10 MHz
  input wire logic arst_n_in, // Async reset, active low
  input wire logic psel_in, // APB select
  input wire logic penable_in, // APB enable
  input wire logic pwrite_in, // APB direction
  input wire logic [7:0] paddr_in, // APB byte address
  input wire logic [31:0] pwdata_in, // APB write data
  output logic [31:0] prdata_out, // APB read data
  output logic pready_out, // APB ready
  output logic pslverr_out, // APB error
  input wire logic los_in, // Loss of signal level
  input wire logic init_err_in, // Initialization error pulse
  input wire logic net_reset_in, // Network init-reset order pulse
  input wire logic hs_start_in, // Handshake started pulse
  input wire logic hs_done_in, // Handshake concluded pulse
  input wire logic hs_mode_sel_in, // Handshake chose this mode
  input wire logic act_done_in, // Activation completed pulse
  input wire logic proc_err_in, // Procedure error in current state
  input wire logic proc_done_in, // State procedures finished pulse
  input wire logic go_idle_in, // Enter idle request pulse
  input wire logic sync_loss_in, // Loss of sync pulse in steady
  input wire llac_pkg::llac_rreg_t rreg_in, // Remote register byte write
  input wire logic [llac_pkg::BITS_W-1:0] bits_req_in, // Requested tone load
  output logic [llac_pkg::BITS_W-1:0] bits_out, // Clamped tone load
  output llac_pkg::llac_state_t state_out, // Link state
  output logic link_up_out, // Link-up flag
  output logic idle_out, // Idle flag
  output logic success_out, // Success flag
  output logic timeout_out, // Activation expired flag
  output llac_pkg::llac_caps_t caps_out // Capabilities-list bits
);

  // ----------------------------------------------------------------
  // Helpers
  // ----------------------------------------------------------------
  // Milliseconds allowed for each activation kind
  function automatic logic [llac_pkg::MS_CNT_W-1:0] limit_ms(input llac_pkg::llac_act_t k);
    unique case (k)
      llac_pkg::ACT_COLD: limit_ms = llac_pkg::MS_CNT_W'(llac_pkg::COLD_START_LIMIT_MS);
      llac_pkg::ACT_WARM: limit_ms = llac_pkg::MS_CNT_W'(llac_pkg::WARM_START_LIMIT_MS);
      llac_pkg::ACT_RESUME: limit_ms = llac_pkg::MS_CNT_W'(llac_pkg::WARM_RESUME_LIMIT_MS);
      llac_pkg::ACT_ERROR: limit_ms = llac_pkg::MS_CNT_W'(llac_pkg::ERROR_RESUME_LIMIT_MS);
    endcase
  endfunction

  // APB access phase qualifiers
  logic apb_acc;
  logic apb_wr;
  assign apb_acc = psel_in && penable_in;
  assign apb_wr = apb_acc && pwrite_in;

  // ----------------------------------------------------------------
  // Registers
  // ----------------------------------------------------------------
  llac_pkg::llac_state_t state_reg;
  llac_pkg::llac_state_t state_next;
  logic [5:0] ctrl_reg; // [1:0] kind, [2] net reset, [5:3] stored only
  logic [3:0] caps_cfg_reg; // [0] mode, [1] us band, [2] ds band, [3] eoc
  logic [llac_pkg::TICK_CNT_W-1:0] tick_cnt_reg;
  logic ms_tick;
  logic [llac_pkg::MS_CNT_W-1:0] ms_cnt_reg;
  logic [llac_pkg::MS_CNT_W-1:0] sync_ms_reg;
  logic in_sync_loss_reg;
  logic link_up_reg;
  logic idle_reg;
  logic success_reg;
  logic err_seen_reg;
  logic timeout_reg;
  logic [llac_pkg::BITS_W-1:0] bits_reg;
  logic [7:0] self_test_reg;
  logic [15:0] atten_reg;
  logic [15:0] margin_reg;
  logic [31:0] rate_reg;
  logic [15:0] fec_corr_reg;
  logic [15:0] fec_uncorr_reg;
  logic entry;
  logic act_expired;
  logic sync_expired;
  llac_pkg::llac_act_t act_kind;
  logic sync_start;

  assign act_kind = llac_pkg::llac_act_t'(ctrl_reg[1:0]);
  assign entry = state_next != state_reg;
  // Recovery restarts the ms grid, otherwise its first ms could be short
  assign sync_start = state_reg == llac_pkg::ST_STEADY && !entry && sync_loss_in
    && !in_sync_loss_reg;

  // ----------------------------------------------------------------
  // Millisecond tick and state timers
  // ----------------------------------------------------------------
  // One shared prescaler keeps every timer on the same time base
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      tick_cnt_reg <= '0;
    else if (entry || sync_start || tick_cnt_reg == llac_pkg::TICK_CNT_W'(TICK_CYCLES - 1))
      tick_cnt_reg <= '0;
    else
      tick_cnt_reg <= tick_cnt_reg + 1'b1;
  end
  assign ms_tick = tick_cnt_reg == llac_pkg::TICK_CNT_W'(TICK_CYCLES - 1);

  // State timer clears on every entry, so timeout reads false there
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      ms_cnt_reg <= '0;
    else if (entry)
      ms_cnt_reg <= '0;
    else if (ms_tick && ms_cnt_reg != '1)
      ms_cnt_reg <= ms_cnt_reg + 1'b1;
  end

  assign act_expired = (state_reg == llac_pkg::ST_ACTIVATE)
    && (ms_cnt_reg >= limit_ms(act_kind));

  // Sync recovery runs inside steady state on its own counter
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      in_sync_loss_reg <= 1'b0;
      sync_ms_reg <= '0;
    end
    else if (state_reg != llac_pkg::ST_STEADY || entry)
    begin
      in_sync_loss_reg <= 1'b0;
      sync_ms_reg <= '0;
    end
    else if (sync_loss_in && !in_sync_loss_reg)
    begin
      in_sync_loss_reg <= 1'b1;
      sync_ms_reg <= '0;
    end
    else if (in_sync_loss_reg && act_done_in)
      in_sync_loss_reg <= 1'b0;
    else if (in_sync_loss_reg && ms_tick)
      sync_ms_reg <= sync_ms_reg + 1'b1;
  end
  assign sync_expired = in_sync_loss_reg
    && sync_ms_reg >= llac_pkg::MS_CNT_W'(llac_pkg::SYNC_RECOVERY_LIMIT_MS);

  // ----------------------------------------------------------------
  // Link state machine
  // ----------------------------------------------------------------
  always_comb
  begin
    state_next = state_reg;
    unique case (state_reg)
      llac_pkg::ST_SILENT:
        if (net_reset_in || ctrl_reg[2])
          state_next = llac_pkg::ST_INIT_RESET;
        else if (hs_start_in)
          state_next = llac_pkg::ST_HANDSHAKE;
      llac_pkg::ST_INIT_RESET:
        if (hs_start_in)
          state_next = llac_pkg::ST_HANDSHAKE;
      llac_pkg::ST_HANDSHAKE:
        if (hs_done_in)
          state_next = hs_mode_sel_in ? llac_pkg::ST_QUIET : llac_pkg::ST_SILENT;
      llac_pkg::ST_QUIET:
        state_next = llac_pkg::ST_ACTIVATE;
      llac_pkg::ST_ACTIVATE:
        if (act_expired)
          state_next = llac_pkg::ST_SILENT;
        else if (act_done_in)
          state_next = llac_pkg::ST_STEADY;
      llac_pkg::ST_STEADY:
        if (sync_expired)
          state_next = llac_pkg::ST_SILENT;
        else if (go_idle_in)
          state_next = llac_pkg::ST_IDLE;
      llac_pkg::ST_IDLE:
        if (act_done_in)
          state_next = llac_pkg::ST_STEADY;
      default:
        state_next = llac_pkg::ST_SILENT;
    endcase
    // Signal loss, and init errors outside steady state, override everything else
    if (los_in || (init_err_in && state_reg != llac_pkg::ST_STEADY))
      state_next = llac_pkg::ST_SILENT;
  end

  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      state_reg <= llac_pkg::ST_SILENT;
    else
      state_reg <= state_next;
  end

  // Expired flag holds until the next activation attempt
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      timeout_reg <= 1'b0;
    else if (act_expired || sync_expired)
      timeout_reg <= 1'b1;
    else if (state_next == llac_pkg::ST_ACTIVATE && entry)
      timeout_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Idle and success flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      idle_reg <= 1'b0;
    else if (entry && state_next == llac_pkg::ST_IDLE)
      idle_reg <= 1'b1;
    else if (entry && state_next == llac_pkg::ST_STEADY)
      idle_reg <= 1'b0;
  end

  // An error anywhere in the state taints success until the next entry
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      err_seen_reg <= 1'b0;
      success_reg <= 1'b0;
    end
    else if (entry)
    begin
      err_seen_reg <= 1'b0;
      success_reg <= 1'b0;
    end
    else
    begin
      err_seen_reg <= err_seen_reg || proc_err_in;
      if (proc_done_in)
        success_reg <= !(err_seen_reg || proc_err_in);
    end
  end

  // ----------------------------------------------------------------
  // Link-up flag and remote data registers
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      self_test_reg <= '0;
      atten_reg <= '0;
      margin_reg <= '0;
      rate_reg <= '0;
      fec_corr_reg <= '0;
      fec_uncorr_reg <= '0;
    end
    else if (rreg_in.valid)
    begin
      unique case (rreg_in.num)
        llac_pkg::RREG_SELF_TEST:
          self_test_reg <= rreg_in.data;
        llac_pkg::RREG_ATTEN:
          if (rreg_in.byte_idx[3:1] == 3'h0)
            atten_reg[rreg_in.byte_idx[0]*8 +: 8] <= rreg_in.data;
        llac_pkg::RREG_MARGIN:
          if (rreg_in.byte_idx[3:1] == 3'h0)
            margin_reg[rreg_in.byte_idx[0]*8 +: 8] <= rreg_in.data;
        llac_pkg::RREG_PERF:
          if (rreg_in.byte_idx[3:2] == 2'(llac_pkg::RATE_BYTE_LO / 4))
            rate_reg[rreg_in.byte_idx[1:0]*8 +: 8] <= rreg_in.data;
          else if (rreg_in.byte_idx[3:1] == 3'(llac_pkg::FEC_CORR_BYTE_LO / 2))
            fec_corr_reg[rreg_in.byte_idx[0]*8 +: 8] <= rreg_in.data;
          else if (rreg_in.byte_idx[3:1] == 3'(llac_pkg::FEC_UNCORR_BYTE_LO / 2))
            fec_uncorr_reg[rreg_in.byte_idx[0]*8 +: 8] <= rreg_in.data;
        default:
          ; // Other registers and reserved bytes are dropped
      endcase
    end
  end

  // Link-up only in steady state with a clean remote self-test
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      link_up_reg <= 1'b0;
    else if (self_test_reg != 8'h00 || (rreg_in.valid && rreg_in.num == llac_pkg::RREG_SELF_TEST
      && rreg_in.data != 8'h00))
      link_up_reg <= 1'b0;
    else
      link_up_reg <= state_next == llac_pkg::ST_STEADY;
  end

  // ----------------------------------------------------------------
  // Tone loading limit
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      bits_reg <= '0;
    else if (bits_req_in > llac_pkg::BITS_W'(llac_pkg::MAX_BITS_PER_TONE))
      bits_reg <= llac_pkg::BITS_W'(llac_pkg::MAX_BITS_PER_TONE);
    else
      bits_reg <= bits_req_in;
  end

  // ----------------------------------------------------------------
  // APB slave: control, capability config
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
    begin
      ctrl_reg <= llac_pkg::CTRL_RESET;
      caps_cfg_reg <= llac_pkg::CAPS_RESET;
    end
    else
    begin
      if (apb_wr && paddr_in == llac_pkg::OFS_CTRL)
        ctrl_reg <= pwdata_in[5:0];
      else if (ctrl_reg[2] && state_reg == llac_pkg::ST_INIT_RESET)
        ctrl_reg[2] <= 1'b0; // Reset order is one-shot
      if (apb_wr && paddr_in == llac_pkg::OFS_CAPS)
        caps_cfg_reg <= pwdata_in[3:0];
    end
  end

  // Capability bits: band and clear-channel flags only where supported
  always_comb
  begin
    caps_out.l1_mode = caps_cfg_reg[0];
    caps_out.us_low_band = caps_cfg_reg[1];
    caps_out.ds_low_band = caps_cfg_reg[2];
    caps_out.eoc_clear = caps_cfg_reg[3];
    caps_out.npar3_dft = caps_cfg_reg[0];
    caps_out.npar3_ce = caps_cfg_reg[0];
  end

  // Read mux; unmapped addresses answer with slave error
  always_ff @(posedge clk_in or negedge arst_n_in)
  begin
    if (!arst_n_in)
      prdata_out <= '0;
    else if (psel_in && !penable_in && !pwrite_in)
    begin
      unique case (paddr_in)
        llac_pkg::OFS_CTRL: prdata_out <= {26'h0, ctrl_reg};
        llac_pkg::OFS_STATUS: prdata_out <= {20'h0, timeout_reg, success_reg, idle_reg,
          link_up_reg, 1'b0, state_reg};
        llac_pkg::OFS_CAPS: prdata_out <= {28'h0, caps_cfg_reg};
        llac_pkg::OFS_ATTEN: prdata_out <= {16'h0, atten_reg};
        llac_pkg::OFS_MARGIN: prdata_out <= {16'h0, margin_reg};
        llac_pkg::OFS_RATE: prdata_out <= rate_reg;
        llac_pkg::OFS_FEC: prdata_out <= {fec_uncorr_reg, fec_corr_reg};
        llac_pkg::OFS_BITCAP: prdata_out <= {24'h0, self_test_reg};
        default: prdata_out <= '0;
      endcase
    end
  end

  always_comb
  begin
    pready_out = 1'b1;
    pslverr_out = apb_acc && !(paddr_in inside {llac_pkg::OFS_CTRL, llac_pkg::OFS_STATUS,
      llac_pkg::OFS_CAPS, llac_pkg::OFS_ATTEN, llac_pkg::OFS_MARGIN, llac_pkg::OFS_RATE,
      llac_pkg::OFS_FEC, llac_pkg::OFS_BITCAP});
  end

  assign state_out = state_reg;
  assign link_up_out = link_up_reg;
  assign idle_out = idle_reg;
  assign success_out = success_reg;
  assign timeout_out = timeout_reg;
  assign bits_out = bits_reg;

  // ----------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------
  property p_bits_cap;
    @(posedge clk_in) disable iff (!arst_n_in)
      bits_out <= llac_pkg::BITS_W'(llac_pkg::MAX_BITS_PER_TONE);
  endproperty
  a_bits_cap: assert property (p_bits_cap) else $error("tone load above cap");

  property p_selftest_down;
    @(posedge clk_in) disable iff (!arst_n_in)
      self_test_reg != 8'h00 |=> !link_up_out;
  endproperty
  a_selftest_down: assert property (p_selftest_down) else $error("link up with bad self-test");

  property p_entry_timer;
    @(posedge clk_in) disable iff (!arst_n_in)
      entry |=> ms_cnt_reg == '0 && !act_expired;
  endproperty
  a_entry_timer: assert property (p_entry_timer) else $error("timer not cleared on entry");

  property p_act_exit;
    @(posedge clk_in) disable iff (!arst_n_in)
      act_expired |=> state_reg == llac_pkg::ST_SILENT;
  endproperty
  a_act_exit: assert property (p_act_exit) else $error("expired activation not abandoned");

  property p_act_bound;
    @(posedge clk_in) disable iff (!arst_n_in)
      state_reg == llac_pkg::ST_ACTIVATE |-> ms_cnt_reg <= limit_ms(act_kind);
  endproperty
  a_act_bound: assert property (p_act_bound) else $error("activation overran limit");

  property p_sync_exit;
    @(posedge clk_in) disable iff (!arst_n_in)
      sync_expired && !los_in |=> state_reg == llac_pkg::ST_SILENT && timeout_out;
  endproperty
  a_sync_exit: assert property (p_sync_exit) else $error("sync recovery not ended");

  property p_idle_flag;
    @(posedge clk_in) disable iff (!arst_n_in)
      $rose(state_reg == llac_pkg::ST_IDLE) |-> idle_out;
  endproperty
  a_idle_flag: assert property (p_idle_flag) else $error("idle flag not set");

  property p_steady_clear;
    @(posedge clk_in) disable iff (!arst_n_in)
      $rose(state_reg == llac_pkg::ST_STEADY) |-> !idle_out;
  endproperty
  a_steady_clear: assert property (p_steady_clear) else $error("idle flag not cleared");

  property p_success;
    @(posedge clk_in) disable iff (!arst_n_in)
      proc_done_in && proc_err_in && !entry |=> !success_out;
  endproperty
  a_success: assert property (p_success) else $error("success despite error");

  property p_los_silent;
    @(posedge clk_in) disable iff (!arst_n_in)
      los_in |=> state_reg == llac_pkg::ST_SILENT;
  endproperty
  a_los_silent: assert property (p_los_silent) else $error("no silent state after loss");

  property p_hs_quiet;
    @(posedge clk_in) disable iff (!arst_n_in)
      state_reg == llac_pkg::ST_HANDSHAKE && hs_done_in && hs_mode_sel_in && !los_in
        && !init_err_in |=> state_reg == llac_pkg::ST_QUIET;
  endproperty
  a_hs_quiet: assert property (p_hs_quiet) else $error("no quiet state after handshake");

endmodule

// [tb/llac_remote_model.sv]
// Remote transceiver model: sends one remote data register as two bytes.
// Assumes a request pulse from the bench on the shared system clock.
`timescale 1ns/1ps
module llac_remote_model (
  input wire logic clk_in, // System clock
  input wire logic send_in, // Send request pulse
  input wire logic [3:0] num_in, // Register number
  input wire logic [3:0] base_in, // Index of the first byte
  input wire logic [15:0] val_in, // Register value
  output llac_pkg::llac_rreg_t rreg_out // Byte stream to the device
);
  logic [1:0] left_reg = 2'h0;
  logic [15:0] val_reg = 16'h0;
  // Byte counter, low byte goes first
  always_ff @(posedge clk_in)
  begin
    if (send_in)
    begin
      left_reg <= 2'h2;
      val_reg <= val_in;
    end
    else if (left_reg != 2'h0)
      left_reg <= left_reg - 2'h1;
  end
  // Idle data is inverted so a stale byte never passes for a new one
  assign rreg_out = {left_reg != 2'h0, num_in, base_in + {3'h0, left_reg == 2'h1},
    (left_reg == 2'h2) ? val_reg[7:0] : (left_reg == 2'h1) ? val_reg[15:8] : ~val_reg[15:8]};
endmodule

// [tb/testbench.sv]
// Bench for the link activation block: walk, timers, remote registers.
// Assumes the remote model feeds rreg_in; APB is driven from here.
`timescale 1ns/1ps
module testbench;
  logic clk_in = 1'b0;
  logic arst_n_in = 1'b0;
  logic psel_in = 1'b0, penable_in = 1'b0, pwrite_in = 1'b0, los_in = 1'b0;
  logic pready_out, pslverr_out, link_up_out, idle_out, success_out, timeout_out, err;
  logic send = 1'b0;
  logic [8:0] strb = 9'h000; // hs_start hs_done act_done proc_err proc_done go_idle sync net init
  logic [7:0] paddr_in = 8'h00;
  logic [31:0] pwdata_in = 32'h0, prdata_out, rd;
  logic [3:0] bits_req_in = 4'h0, bits_out, snum = 4'h0, sbase = 4'h0;
  logic [15:0] sval = 16'h0;
  llac_pkg::llac_rreg_t rreg_in;
  llac_pkg::llac_state_t state_out;
  llac_pkg::llac_caps_t caps_out;
  int n_mismatch = 0, num_checks = 0;
  typedef struct {logic [3:0] n; logic [3:0] b; logic [15:0] v; logic [7:0] a; logic [31:0] e;}
    llac_row_t;
  llac_row_t rows [8] = '{'{4'h6, 4'h0, 16'h1234, llac_pkg::OFS_ATTEN, 32'h1234},
    '{4'h7, 4'h0, 16'h0056, llac_pkg::OFS_MARGIN, 32'h56},
    '{4'h4, 4'h0, 16'h5678, llac_pkg::OFS_RATE, 32'h5678},
    '{4'h4, 4'h2, 16'h1234, llac_pkg::OFS_RATE, 32'h12345678},
    '{4'h4, 4'h4, 16'hBEEF, llac_pkg::OFS_FEC, 32'hBEEF},
    '{4'h4, 4'h8, 16'h0102, llac_pkg::OFS_FEC, 32'h0102BEEF},
    '{4'h4, 4'h6, 16'hFFFF, llac_pkg::OFS_FEC, 32'h0102BEEF},
    '{4'h3, 4'h0, 16'h0505, llac_pkg::OFS_BITCAP, 32'h5}};
  always #50 clk_in = ~clk_in;
  llac_top #(.TICK_CYCLES(10)) llac_top_inst (.clk_in(clk_in), .arst_n_in(arst_n_in),
    .psel_in(psel_in), .penable_in(penable_in), .pwrite_in(pwrite_in), .paddr_in(paddr_in),
    .pwdata_in(pwdata_in), .prdata_out(prdata_out), .pready_out(pready_out),
    .pslverr_out(pslverr_out), .los_in(los_in), .init_err_in(strb[8]), .net_reset_in(strb[7]),
    .hs_start_in(strb[0]), .hs_done_in(strb[1]), .hs_mode_sel_in(1'b1), .act_done_in(strb[2]),
    .proc_err_in(strb[3]), .proc_done_in(strb[4]), .go_idle_in(strb[5]), .sync_loss_in(strb[6]),
    .rreg_in(rreg_in), .bits_req_in(bits_req_in), .bits_out(bits_out), .state_out(state_out),
    .link_up_out(link_up_out), .idle_out(idle_out), .success_out(success_out),
    .timeout_out(timeout_out), .caps_out(caps_out));
  llac_remote_model llac_remote_model_inst (.clk_in(clk_in), .send_in(send), .num_in(snum),
    .base_in(sbase),
    .val_in(sval), .rreg_out(rreg_in));
  task automatic tick(input int n);
    repeat (n) @(posedge clk_in);
  endtask
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    num_checks++;
    if (got !== exp)
    begin
      n_mismatch++;
      $display("[FAIL] t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask
  // Strobe pulse, then one edge so the new state is readable
  task automatic pulse(input int b);
    strb <= 9'h001 << b;
    tick(1);
    strb <= 9'h000;
    tick(1);
  endtask
  // Release after the sampling edge, one idle edge so requests never collide
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd);
    psel_in <= 1'b1;
    pwrite_in <= wr;
    paddr_in <= a;
    pwdata_in <= wd;
    tick(1);
    penable_in <= 1'b1;
    tick(1);
    while (pready_out !== 1'b1)
      tick(1);
    rd = prdata_out;
    err = pslverr_out;
    psel_in <= 1'b0;
    penable_in <= 1'b0;
    tick(1);
  endtask
  task automatic walk_to_act();
    pulse(0);
    chk(32'(state_out), 32'h04);
    pulse(1);
    chk(32'(state_out), 32'h08);
    tick(1);
    chk(32'(state_out), 32'h10);
  endtask
  task automatic report_and_stop();
    if (n_mismatch == 0 && num_checks > 0)
      $display("RESULT: PASS");
    else
      $display("RESULT: FAIL");
    $finish;
  endtask
  // Hang guard, well past the longest timer test
  initial
  begin
    tick(6000);
    n_mismatch++;
    report_and_stop();
  end
  initial
  begin
    tick(4);
    arst_n_in <= 1'b1;
    tick(1);
    chk(32'(state_out), 32'h01);
    chk({link_up_out, idle_out, success_out, timeout_out}, 32'h0);
    chk(32'(caps_out), 32'h0);
    apb(1'b1, llac_pkg::OFS_CAPS, 32'hB);
    chk(32'(caps_out), 32'h37);
    for (int i = 0; i < 16; i++)
    begin
      bits_req_in <= 4'(i);
      tick(2);
      chk(32'(bits_out), (i > 12) ? 32'd12 : 32'(i));
    end
    walk_to_act();
    pulse(2);
    chk({state_out, link_up_out}, {7'h20, 1'b1});
    for (int i = 0; i < 8; i++)
    begin
      snum <= rows[i].n;
      sbase <= rows[i].b;
      sval <= rows[i].v;
      send <= 1'b1;
      tick(1);
      send <= 1'b0;
      tick(4);
      apb(1'b0, rows[i].a, 32'h0);
      chk(rd, rows[i].e);
    end
    chk(32'(link_up_out), 32'h0);
    pulse(4);
    chk(32'(success_out), 32'h1);
    pulse(3);
    pulse(4);
    chk(32'(success_out), 32'h0);
    pulse(5);
    chk({state_out, idle_out}, {7'h40, 1'b1});
    pulse(4);
    chk(32'(success_out), 32'h1);
    pulse(2);
    chk({state_out, idle_out}, {7'h20, 1'b0});
    apb(1'b0, 8'h40, 32'h0);
    chk(32'(err), 32'h1);
    chk(rd, 32'h0);
    los_in <= 1'b1;
    tick(2);
    chk(32'(state_out), 32'h01);
    los_in <= 1'b0;
    apb(1'b1, llac_pkg::OFS_CTRL, 32'h2);
    pulse(7);
    chk(32'(state_out), 32'h02);
    walk_to_act();
    tick(900);
    chk(32'(timeout_out), 32'h0);
    tick(200);
    chk(32'(timeout_out), 32'h1);
    // Sync loss in steady state: recovery window, then back to silent
    walk_to_act();
    pulse(2);
    pulse(6);
    tick(1990);
    chk({state_out, timeout_out}, {7'h20, 1'b0});
    tick(20);
    chk({state_out, timeout_out}, {7'h01, 1'b1});
    // Initialization error during handshake
    pulse(0);
    pulse(8);
    chk(32'(state_out), 32'h01);
    // Reset in mid-run clears the expired flag
    arst_n_in <= 1'b0;
    tick(2);
    chk({state_out, timeout_out}, {7'h01, 1'b0});
    arst_n_in <= 1'b1;
    tick(2);
    chk(32'(state_out), 32'h01);
    report_and_stop();
  end
endmodule
